// >>> inc/porch_defines.svh
// Purpose: offsets, field positions and reset values of the porch block
// Assumes: register index = printed offset, byte address = 4 * index
// Notes: definitions only
`ifndef PORCH_DEFINES_SVH
`define PORCH_DEFINES_SVH

// ****************************************
// register indices (word addresses)
// ****************************************
`define IDX_CHAN_MODE 8'h10
`define IDX_A_HORIZ_BACK_PORCH 8'h34
`define IDX_B_HORIZ_BACK_PORCH 8'h35
`define IDX_A_VERT_BACK_PORCH 8'h36
`define IDX_B_VERT_BACK_PORCH 8'h37
`define IDX_A_HORIZ_FRONT_PORCH 8'h38
`define IDX_B_HORIZ_FRONT_PORCH 8'h39
`define IDX_A_VERT_FRONT_PORCH 8'h3A
`define IDX_B_VERT_FRONT_PORCH 8'h3B
`define IDX_PATTERN_ENABLE 8'h3C
`define IDX_STATUS 8'h40
`define IDX_GEOMETRY 8'h41

// ****************************************
// field positions and codes
// ****************************************
`define CHAN_MODE_LSB 5
`define CHAN_MODE_SPLIT 2'h2
`define FIRST_ENABLE_BIT 4
`define SECOND_ENABLE_BIT 0
`define PORCH_RESET 8'h00
`define GEOMETRY_RESET 32'h00000000
`endif

// >>> inc/porch_pkg.sv
// Purpose: types shared by the porch timing block
// Assumes: nothing beyond the defines header
// Notes: carriers are packed structs
package porch_pkg;
  // one video beat: enable and the two syncs
  typedef struct packed {
    logic de;
    logic hsync;
    logic vsync;
  } video_t;

  // complete frame geometry for one generator
  typedef struct packed {
    logic [11:0] hact;
    logic [7:0] hfp;
    logic [3:0] hsw;
    logic [7:0] hbp;
    logic [11:0] vact;
    logic [7:0] vfp;
    logic [3:0] vsw;
    logic [7:0] vbp;
  } timing_t;
endpackage

// >>> hw/test_pattern_porch_timing.sv
// Purpose: porch registers and test pattern timing for two video links
// Assumes: sys_clk is the pixel clock; Avalon-MM word addressing
// Notes: on behaviour
// Notes on behaviour
// - porches apply only to generated pattern
// - second link back porch lines in split mode
// - first front porch clocks, shared with second
// - second link front porch clocks in split mode
// - first front porch lines, shared with second
// - second link front porch lines in split mode
// - first enable bit starts first link pattern
//
// Register access over Avalon-MM is this design's own decision.
`include "porch_defines.svh"

// ****************************************
// one raster timing generator
// ****************************************
module pattern_raster
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic enable,
  input porch_pkg::timing_t tim,
  output porch_pkg::video_t vid
);
  logic [13:0] hcnt; // pixel position in the line
  logic [13:0] vcnt; // line position in the frame
  logic [13:0] h_fp_end; // first clock of sync
  logic [13:0] h_sw_end; // first clock of back porch
  logic [13:0] h_total;
  logic [13:0] v_fp_end;
  logic [13:0] v_sw_end;
  logic [13:0] v_total;
  logic line_end;

  // region edges; zero-length regions simply vanish
  assign h_fp_end = 14'(tim.hact) + 14'(tim.hfp);
  assign h_sw_end = h_fp_end + 14'(tim.hsw);
  assign h_total = h_sw_end + 14'(tim.hbp);
  assign v_fp_end = 14'(tim.vact) + 14'(tim.vfp);
  assign v_sw_end = v_fp_end + 14'(tim.vsw);
  assign v_total = v_sw_end + 14'(tim.vbp);
  // a line of all zeros still lasts one clock
  assign line_end = (hcnt + 14'h0001 >= h_total);

  // horizontal counter, restarts each line
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      hcnt <= 14'h0000;
    else if (!enable || line_end)
      hcnt <= 14'h0000;
    else
      hcnt <= hcnt + 14'h0001;
  end

  // vertical counter, steps at each line end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      vcnt <= 14'h0000;
    else if (!enable)
      vcnt <= 14'h0000;
    else if (line_end)
    begin
      if (vcnt + 14'h0001 >= v_total)
        vcnt <= 14'h0000;
      else
        vcnt <= vcnt + 14'h0001;
    end
  end

  // registered outputs decoded from the counters
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      vid <= '0;
    else
    begin
      vid.de <= enable && hcnt < 14'(tim.hact) && vcnt < 14'(tim.vact);
      vid.hsync <= enable && hcnt >= h_fp_end && hcnt < h_sw_end;
      vid.vsync <= enable && vcnt >= v_fp_end && vcnt < v_sw_end;
    end
  end
endmodule

// ****************************************
// register file and link output selection
// ****************************************
module test_pattern_porch_timing
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input porch_pkg::video_t first_link_in,
  input porch_pkg::video_t second_link_in,
  output porch_pkg::video_t first_link_out,
  output porch_pkg::video_t second_link_out
);
  logic [1:0] chan_mode; // 2'h2 gives second link its own timing
  logic [7:0] chan_a_horiz_back_porch;
  logic [7:0] chan_b_horiz_back_porch;
  logic [7:0] chan_a_vert_back_porch;
  logic [7:0] chan_b_vert_back_porch;
  logic [7:0] chan_a_horiz_front_porch;
  logic [7:0] chan_b_horiz_front_porch;
  logic [7:0] chan_a_vert_front_porch;
  logic [7:0] chan_b_vert_front_porch;
  logic first_link_pattern_enable;
  logic second_link_pattern_enable;
  logic [31:0] geometry; // active sizes and sync widths, both links
  logic split; // second link has its own porches
  logic wr_go; // write accepted this edge
  logic [31:0] next_readdata;
  porch_pkg::timing_t tim_a;
  porch_pkg::timing_t tim_b;
  porch_pkg::video_t pat_a;
  porch_pkg::video_t pat_b;

  assign split = (chan_mode == `CHAN_MODE_SPLIT);
  assign wr_go = write && !waitrequest && byteenable[0];

  // ****************************************
  // bus handshake
  // ****************************************
  // one wait state: low for exactly one cycle per request
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      waitrequest <= 1'b1;
    else if (!waitrequest)
      waitrequest <= 1'b1;
    else if (read || write)
      waitrequest <= 1'b0;
  end

  // read mux; unmapped indices read zero
  always_comb
  begin
    next_readdata = 32'h00000000;
    unique case (address)
      `IDX_CHAN_MODE: next_readdata[6:5] = chan_mode;
      `IDX_A_HORIZ_BACK_PORCH: next_readdata[7:0] = chan_a_horiz_back_porch;
      `IDX_B_HORIZ_BACK_PORCH: next_readdata[7:0] = chan_b_horiz_back_porch;
      `IDX_A_VERT_BACK_PORCH: next_readdata[7:0] = chan_a_vert_back_porch;
      `IDX_B_VERT_BACK_PORCH: next_readdata[7:0] = chan_b_vert_back_porch;
      `IDX_A_HORIZ_FRONT_PORCH: next_readdata[7:0] = chan_a_horiz_front_porch;
      `IDX_B_HORIZ_FRONT_PORCH: next_readdata[7:0] = chan_b_horiz_front_porch;
      `IDX_A_VERT_FRONT_PORCH: next_readdata[7:0] = chan_a_vert_front_porch;
      `IDX_B_VERT_FRONT_PORCH: next_readdata[7:0] = chan_b_vert_front_porch;
      `IDX_PATTERN_ENABLE:
      begin
        next_readdata[`FIRST_ENABLE_BIT] = first_link_pattern_enable;
        next_readdata[`SECOND_ENABLE_BIT] = second_link_pattern_enable;
      end
      // live state: pattern outputs of both generators
      `IDX_STATUS: next_readdata[5:0] = {pat_b, pat_a};
      `IDX_GEOMETRY: next_readdata = geometry;
      default: next_readdata = 32'h00000000;
    endcase
  end

  // read data loaded as waitrequest drops, held until next read request
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      readdata <= 32'h00000000;
    else if (read && waitrequest)
      readdata <= next_readdata;
  end

  // ****************************************
  // register writes, low byte lane only, geometry on all four lanes
  // ****************************************
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      chan_mode <= 2'h0;
      chan_a_horiz_back_porch <= `PORCH_RESET;
      chan_b_horiz_back_porch <= `PORCH_RESET;
      chan_a_vert_back_porch <= `PORCH_RESET;
      chan_b_vert_back_porch <= `PORCH_RESET;
      chan_a_horiz_front_porch <= `PORCH_RESET;
      chan_b_horiz_front_porch <= `PORCH_RESET;
      chan_a_vert_front_porch <= `PORCH_RESET;
      chan_b_vert_front_porch <= `PORCH_RESET;
      first_link_pattern_enable <= 1'b0;
      second_link_pattern_enable <= 1'b0;
    end
    else if (wr_go)
    begin
      unique case (address)
        `IDX_CHAN_MODE: chan_mode <= writedata[6:5];
        `IDX_A_HORIZ_BACK_PORCH: chan_a_horiz_back_porch <= writedata[7:0];
        `IDX_B_HORIZ_BACK_PORCH: chan_b_horiz_back_porch <= writedata[7:0];
        `IDX_A_VERT_BACK_PORCH: chan_a_vert_back_porch <= writedata[7:0];
        `IDX_B_VERT_BACK_PORCH: chan_b_vert_back_porch <= writedata[7:0];
        `IDX_A_HORIZ_FRONT_PORCH: chan_a_horiz_front_porch <= writedata[7:0];
        `IDX_B_HORIZ_FRONT_PORCH: chan_b_horiz_front_porch <= writedata[7:0];
        `IDX_A_VERT_FRONT_PORCH: chan_a_vert_front_porch <= writedata[7:0];
        `IDX_B_VERT_FRONT_PORCH: chan_b_vert_front_porch <= writedata[7:0];
        `IDX_PATTERN_ENABLE:
        begin
          first_link_pattern_enable <= writedata[`FIRST_ENABLE_BIT];
          second_link_pattern_enable <= writedata[`SECOND_ENABLE_BIT];
        end
        default: ; // unmapped writes are dropped
      endcase
    end
  end

  // geometry word takes all four byte lanes
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      geometry <= `GEOMETRY_RESET;
    else if (write && !waitrequest && address == `IDX_GEOMETRY)
    begin
      for (int i = 0; i < 4; i++)
        if (byteenable[i])
          geometry[i*8 +: 8] <= writedata[i*8 +: 8];
    end
  end

  // ****************************************
  // per-link timing selection
  // ****************************************
  // first link porches also serve the second unless split
  always_comb
  begin
    tim_a.hact = geometry[11:0];
    tim_a.vact = geometry[23:12];
    tim_a.hsw = geometry[27:24];
    tim_a.vsw = geometry[31:28];
    tim_a.hfp = chan_a_horiz_front_porch;
    tim_a.hbp = chan_a_horiz_back_porch;
    tim_a.vfp = chan_a_vert_front_porch;
    tim_a.vbp = chan_a_vert_back_porch;
    tim_b = tim_a;
    if (split)
    begin
      tim_b.hfp = chan_b_horiz_front_porch;
      tim_b.hbp = chan_b_horiz_back_porch;
      tim_b.vfp = chan_b_vert_front_porch;
      tim_b.vbp = chan_b_vert_back_porch;
    end
  end

  // first generator runs on its enable
  pattern_raster gen_a
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .enable(first_link_pattern_enable),
    .tim(tim_a),
    .vid(pat_a)
  );

  // second generator only meaningful in split mode
  pattern_raster gen_b
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .enable(second_link_pattern_enable && split),
    .tim(tim_b),
    .vid(pat_b)
  );

  // ****************************************
  // output selection
  // ****************************************
  // incoming video passes untouched when no pattern is chosen
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      first_link_out <= '0;
      second_link_out <= '0;
    end
    else
    begin
      first_link_out <= first_link_pattern_enable ? pat_a : first_link_in;
      if (split)
        second_link_out <= second_link_pattern_enable ? pat_b : second_link_in;
      else
        // shared timing: second link mirrors first pattern
        second_link_out <= first_link_pattern_enable ? pat_a : second_link_in;
    end
  end
endmodule

// >>> verification/porch_timing_sva.sv
// Purpose: port checker for the porch timing block
// Assumes: pattern controls are seen through completed bus writes
// Notes: bound to the top module below
module porch_timing_sva
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input porch_pkg::video_t first_link_in,
  input porch_pkg::video_t second_link_in,
  input porch_pkg::video_t first_link_out,
  input porch_pkg::video_t second_link_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // every property here belongs to the one pixel clock domain
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  logic done; // a write takes effect now
  logic en_a, en_b, split; // shadow pattern controls
  logic [7:0] hfp_a, gap; // shadow porch, clocks since de
  logic [1:0] quiet; // settle count after a control write
  logic seen; // de seen since the last hsync
  assign done = write && !waitrequest && byteenable[0];
  // *****
  // shadow state
  // *****
  // three quiet cycles cover the output register after a control change
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      {en_a, en_b, split, hfp_a, quiet, gap, seen} <= '0;
    end
    else
    begin
      if (done && address == 8'h3C)
        {en_a, en_b} <= {writedata[4], writedata[0]};
      if (done && address == 8'h10)
        split <= writedata[6:5] == 2'h2;
      if (done && address == 8'h38)
        hfp_a <= writedata[7:0];
      if (done && (address == 8'h3C || address == 8'h10))
        quiet <= 2'h0;
      else if (quiet != 2'h3)
        quiet <= quiet + 2'h1;
      gap <= first_link_out.de ? 8'h00 : gap + 8'h01;
      seen <= quiet == 2'h3 && en_a && (first_link_out.de || (seen && !first_link_out.hsync));
    end
  sequence req_s;
    (read || write) && waitrequest;
  endsequence
  sequence answer_s;
    !waitrequest ##1 waitrequest;
  endsequence
  bus_wait_a: assert property (
    req_s |=> answer_s) else $error("bus answer not one cycle");
  idle_wait_a: assert property (
    !read && !write |=> waitrequest) else $error("answer without request");
  read_hold_a: assert property (
    !read |=> $stable(readdata)) else $error("read data moved");
  unmapped_read_a: assert property (read && waitrequest
    && !(address inside {8'h10, [8'h34:8'h3C], 8'h40, 8'h41}) |=> readdata == 32'h0)
    else $error("unmapped read not zero");
  pass_first_a: assert property (
    quiet == 2'h3 && !en_a |-> first_link_out == $past(first_link_in))
    else $error("first link not passed through");
  pass_second_a: assert property (
    quiet == 2'h3 && !(split ? en_b : en_a) |-> second_link_out == $past(second_link_in))
    else $error("second link not passed through");
  shared_timing_a: assert property (
    quiet == 2'h3 && en_a && !split |-> second_link_out == first_link_out)
    else $error("second link not sharing pattern");
  first_porch_a: assert property (
    $rose(first_link_out.hsync) && seen |-> gap == hfp_a)
    else $error("front porch length wrong");
endmodule

bind test_pattern_porch_timing porch_timing_sva checker_i (.sys_clk(sys_clk), .nrst(nrst),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .first_link_in(first_link_in), .second_link_in(second_link_in),
  .first_link_out(first_link_out), .second_link_out(second_link_out));

// >>> verification/panel_receiver.sv
// Purpose: panel receiver model that measures porch lengths
// Assumes: active-high de and syncs; vsync edges fall on line starts
// Notes: outputs hold the last finished measurement
module panel_receiver
(
  input wire logic sys_clk,
  input wire logic nrst,
  input porch_pkg::video_t vid,
  output logic [7:0] hfp,
  output logic [7:0] vfp,
  output logic [7:0] vbp
);
  timeunit 1ns;
  timeprecision 1ps;
  porch_pkg::video_t prev; // last beat, for edges
  logic [7:0] gap, hc, hv; // clocks since de, lines since de, lines since vsync
  logic after_de, in_vbp; // inside front porch, before first active line
  // *****
  // measurement
  // *****
  // the last active line owns one hsync, hence the minus one
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      {prev, gap, hc, hv, after_de, in_vbp, hfp, vfp, vbp} <= '0;
    end
    else
    begin
      prev <= vid;
      gap <= vid.de ? 8'h00 : gap + 8'h01;
      after_de <= vid.de || (after_de && !vid.hsync);
      in_vbp <= vid.vsync || (in_vbp && !vid.de);
      hc <= vid.de ? 8'h00 : hc + 8'(vid.hsync && !prev.hsync);
      hv <= vid.vsync ? 8'h00 : hv + 8'(vid.hsync && !prev.hsync);
      if (vid.hsync && !prev.hsync && after_de)
        hfp <= gap;
      if (vid.vsync && !prev.vsync)
        vfp <= hc - 8'h01;
      if (vid.de && !prev.de && in_vbp)
        vbp <= hv;
    end
endmodule

// >>> verification/test_pattern_porch_timing_bench.sv
// Purpose: register and pattern porch tests of the porch timing block
// Assumes: sys_clk at 100 MHz, one wait cycle per access
// Notes: porches are measured by one receiver on each link
module test_pattern_porch_timing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0; // clock, reset, strobes
  logic [7:0] address = 8'h00; // word index
  logic [31:0] writedata = 32'h0, readdata, q; // bus data, last read
  logic [3:0] byteenable = 4'h0; // lane enables
  logic waitrequest; // slave stall
  porch_pkg::video_t first_link_in = '0, second_link_in = '0; // pass-through video
  porch_pkg::video_t first_link_out, second_link_out; // link outputs
  logic [7:0] a_h, a_v, a_b, b_h, b_v, b_b; // measured porches
  int errors = 0, comparisons = 0;
  test_pattern_porch_timing dut (.sys_clk(sys_clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .first_link_in(first_link_in),
    .second_link_in(second_link_in), .first_link_out(first_link_out),
    .second_link_out(second_link_out));
  panel_receiver first_rx (.sys_clk(sys_clk), .nrst(nrst), .vid(first_link_out),
    .hfp(a_h), .vfp(a_v), .vbp(a_b));
  panel_receiver second_rx (.sys_clk(sys_clk), .nrst(nrst), .vid(second_link_out),
    .hfp(b_h), .vfp(b_v), .vbp(b_b));
  // *****
  // clock, video source, tasks
  // *****
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  // changing input video shows any pass-through slip
  always @(posedge sys_clk)
  begin
    first_link_in <= porch_pkg::video_t'(3'(first_link_in) + 3'h1);
    second_link_in <= porch_pkg::video_t'(3'(second_link_in) + 3'h3);
  end
  task automatic complete_run();
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // holds the request until waitrequest is sampled low
  task automatic access(input logic [7:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] be);
    int n;
    n = 0;
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    byteenable <= be;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 20)
    begin
      errors++;
      $display("unexpected at %0t: bus answer never came", $time);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    access(a, 1'b1, d, 4'hF);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    access(a, 1'b0, 32'h0, 4'hF);
    check(q, exp);
  endtask
  task automatic rx(input logic [7:0] h, v, b, eh, ev, eb);
    check({24'h0, h}, {24'h0, eh});
    check({24'h0, v}, {24'h0, ev});
    check({24'h0, b}, {24'h0, eb});
  endtask
  // *****
  // tests
  // *****
  initial
  begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 5; i++)
    begin
      rd(8'h37 + 8'(i), 32'h0);
      wr(8'h37 + 8'(i), 32'hA0 + 32'(i));
      rd(8'h37 + 8'(i), 32'hA0 + 32'(i));
    end
    access(8'h38, 1'b1, 32'hFF, 4'hE); // lane 0 off, so ignored
    rd(8'h38, 32'hA1);
    wr(8'h20, 32'h5A);
    rd(8'h20, 32'h0);
    // shared timing: 4 clocks active, 2 lines active, syncs 2 clocks and 1 line
    wr(8'h41, 32'h12002004);
    rd(8'h41, 32'h12002004);
    wr(8'h34, 32'h2);
    wr(8'h36, 32'h1);
    wr(8'h38, 32'h3);
    wr(8'h3A, 32'h2);
    wr(8'h3C, 32'h10);
    repeat (400) @(posedge sys_clk);
    rx(a_h, a_v, a_b, 8'h3, 8'h2, 8'h1);
    rx(b_h, b_v, b_b, 8'h3, 8'h2, 8'h1);
    // split mode: second link takes its own porches
    wr(8'h35, 32'h2);
    wr(8'h37, 32'h3);
    wr(8'h39, 32'h5);
    wr(8'h3B, 32'h1);
    wr(8'h10, 32'h40);
    rd(8'h10, 32'h40);
    wr(8'h3C, 32'h11);
    repeat (400) @(posedge sys_clk);
    rx(b_h, b_v, b_b, 8'h5, 8'h1, 8'h3);
    rx(a_h, a_v, a_b, 8'h3, 8'h2, 8'h1);
    wr(8'h3C, 32'h0);
    repeat (20) @(posedge sys_clk);
    // both generators stopped, so the live pattern word is quiet
    rd(8'h40, 32'h0);
    complete_run();
  end
  // cuts a hang short
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
